//--- design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_s;

    sync_state_s s_r;
    sync_state_s s_nxt;

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.meta   = async_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign sync_out = s_r.stable;

endmodule : pin_sync

`default_nettype wire

//--- design/spi_core.sv
`timescale 1ns/1ps
`default_nettype none

module spi_core #(
    parameter int DEPTH = spi_pkg::FIFO_DEPTH
) (
    input  wire logic                             clk,
    input  wire logic                             reset_n,
    input  wire logic                             psc_reset_n,
    input  wire logic                             reset_release,
    input  wire logic                             clock_source_bit,
    input  wire logic                             master_bit,
    input  wire logic                             block_enable_bit,
    input  wire logic [1:0]                       pin_function,
    input  wire spi_pkg::word_format_s [3:0]      word_format_register,
    input  wire spi_pkg::select_delay_s           select_delay_register,
    input  wire logic [1:0]                       select_idle_level_bits,
    input  wire logic                             rx_irq_enable,
    input  wire logic                             len_irq_enable,
    input  wire logic                             rx_irq_line_select,
    input  wire logic                             len_irq_line_select,
    input  wire logic                             dma_request_enable,
    input  wire spi_pkg::tx_word_s                tx_word,
    input  wire logic                             tx_valid,
    output logic                                  tx_ready,
    input  wire logic                             rx_read,
    input  wire logic                             rx_flag_clear,
    input  wire logic                             len_flag_clear,
    output logic [spi_pkg::DATA_W-1:0]            rx_buffer_register,
    output logic                                  rx_complete_flag,
    output logic                                  length_error_flag,
    output logic                                  irq_line_zero,
    output logic                                  irq_line_one,
    output logic                                  dma_tx_request,
    output logic                                  dma_rx_request,
    input  wire logic                             serial_clock_pin_i,
    output logic                                  serial_clock_pin_o,
    output logic                                  serial_clock_pin_oe,
    input  wire logic                             slave_in_master_out_pin_i,
    output logic                                  slave_in_master_out_pin_o,
    output logic                                  slave_in_master_out_pin_oe,
    input  wire logic                             slave_out_master_in_pin_i,
    output logic                                  slave_out_master_in_pin_o,
    output logic                                  slave_out_master_in_pin_oe,
    input  wire logic [1:0]                       chip_select_pins_i,
    output logic [1:0]                            chip_select_pins_o,
    output logic [1:0]                            chip_select_pins_oe
);

    localparam int DW = spi_pkg::DATA_W;
    localparam int IW = $clog2(DW);

    spi_pkg::core_state_s  s_r;
    spi_pkg::core_state_s  s_nxt;
    spi_pkg::tx_word_s     head;
    spi_pkg::word_format_s cur_fmt;
    spi_pkg::word_format_s head_fmt;
    logic [spi_pkg::SYNC_W-1:0] pin_s;
    logic                  head_valid;
    logic                  pop;
    logic                  word_done;
    logic                  len_err;
    logic                  master_mode;
    logic                  sel;
    logic                  sclk_edge;
    logic                  srst_n;
    logic                  sclk_s;
    logic                  mosi_s;
    logic                  somi_s;
    logic [1:0]            cs_s;
    logic                  rx_irq;
    logic                  len_irq;
    logic                  in_setup;
    logic                  in_shift;
    logic                  in_hold;
    logic                  in_keep;
    logic                  in_idle;

    ////////////////////////////////////////////////////////////////////////////
    // bit helpers

    function automatic logic out_bit(input logic [DW-1:0] sh, input spi_pkg::word_format_s f);
        return f.shift_order_bit ? sh[0] : sh[IW'(f.char_length_field - 5'h01)];
    endfunction : out_bit

    function automatic logic [DW-1:0] shift_in(input logic [DW-1:0] sh, input logic b,
                                               input spi_pkg::word_format_s f);
        logic [DW-1:0] r;
        if (f.shift_order_bit)
        begin
            r = sh >> 1;
            r[IW'(f.char_length_field - 5'h01)] = b;
        end
        else
            r = {sh[DW-2:0], b};
        return r;
    endfunction : shift_in

    function automatic spi_pkg::core_state_s load_word(input spi_pkg::core_state_s cur,
                                                       input spi_pkg::tx_word_s w,
                                                       input spi_pkg::word_format_s f);
        spi_pkg::core_state_s r;
        r      = cur;
        r.word = w;
        r.sh   = w.data;
        r.cnt  = 6'h00;
        r.div  = f.clock_divider_field;
        r.sclk = f.clock_polarity_bit;
        r.mosi = f.clock_phase_bit ? out_bit(w.data, f) : cur.mosi;
        return r;
    endfunction : load_word

    ////////////////////////////////////////////////////////////////////////////
    // resets, pins and word queue

    // emulator resets are not wired here, so they leave every register alone
    assign srst_n = reset_n & psc_reset_n & reset_release;

    pin_sync #(
        .WIDTH    (spi_pkg::SYNC_W)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({chip_select_pins_i, slave_out_master_in_pin_i, slave_in_master_out_pin_i, serial_clock_pin_i}),
        .sync_out (pin_s)
    );

    assign sclk_s = pin_s[0];
    assign mosi_s = pin_s[1];
    assign somi_s = pin_s[2];
    assign cs_s   = pin_s[4:3];

    spi_fifo #(
        .WIDTH     ($bits(spi_pkg::tx_word_s)),
        .DEPTH     (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (srst_n),
        .in_data   (tx_word),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (head),
        .out_valid (head_valid),
        .out_ready (pop)
    );

    assign master_mode = clock_source_bit & master_bit;
    assign sel         = |(~cs_s & pin_function);
    assign sclk_edge   = sclk_s != s_r.prev_sclk;
    assign cur_fmt     = word_format_register[s_r.word.format_select_field];
    assign head_fmt    = word_format_register[head.format_select_field];
    assign in_idle     = s_r.st == spi_pkg::st_idle;
    assign in_setup    = s_r.st == spi_pkg::st_setup;
    assign in_shift    = s_r.st == spi_pkg::st_shift;
    assign in_hold     = s_r.st == spi_pkg::st_hold;
    assign in_keep     = s_r.st == spi_pkg::st_keep;

    ////////////////////////////////////////////////////////////////////////////
    // transfer engine

    always_comb
    begin
        s_nxt           = s_r;
        pop             = 1'b0;
        word_done       = 1'b0;
        len_err         = 1'b0;
        s_nxt.prev_sclk = sclk_s;
        s_nxt.dma_rx    = 1'b0;
        case (s_r.st)
            spi_pkg::st_idle:
            begin
                s_nxt.somi_oe = 1'b0;
                s_nxt.sclk    = head_valid ? head_fmt.clock_polarity_bit : cur_fmt.clock_polarity_bit;
                if (block_enable_bit && master_mode && head_valid)
                begin
                    pop       = 1'b1;
                    s_nxt     = load_word(s_r, head, head_fmt);
                    s_nxt.dly = 9'(select_delay_register.select_setup_field) + 9'(spi_pkg::SETUP_EXTRA - 1);
                    s_nxt.st  = (|pin_function) ? spi_pkg::st_setup : spi_pkg::st_shift;
                end
                else if (block_enable_bit && !master_mode && sel)
                begin
                    pop           = head_valid;
                    s_nxt.word    = head_valid ? head : s_r.word;
                    s_nxt.sh      = head_valid ? head.data : '0;
                    s_nxt.cnt     = 6'h00;
                    s_nxt.somi    = out_bit(s_nxt.sh, head_valid ? head_fmt : cur_fmt);
                    s_nxt.somi_oe = 1'b1;
                    s_nxt.st      = spi_pkg::st_slv_shift;
                end
            end
            spi_pkg::st_setup:
            begin
                if (s_r.dly == 9'h000)
                    s_nxt.st = spi_pkg::st_shift;
                else
                    s_nxt.dly = s_r.dly - 9'h001;
            end
            spi_pkg::st_shift:
            begin
                if (s_r.div == 8'h00)
                begin
                    s_nxt.div  = cur_fmt.clock_divider_field;
                    s_nxt.sclk = ~s_r.sclk;
                    s_nxt.cnt  = s_r.cnt + 6'h01;
                    if (s_r.cnt[0] == cur_fmt.clock_phase_bit)
                        s_nxt.mosi = out_bit(s_r.sh, cur_fmt);
                    else
                        s_nxt.sh = shift_in(s_r.sh, somi_s, cur_fmt);
                    if (s_nxt.cnt == {cur_fmt.char_length_field, 1'b0})
                    begin
                        word_done = 1'b1;
                        s_nxt.dly = 9'(select_delay_register.select_hold_field) + 9'(spi_pkg::HOLD_EXTRA - 1);
                        s_nxt.st  = s_r.word.select_keep_bit ? spi_pkg::st_keep : spi_pkg::st_hold;
                    end
                end
                else
                    s_nxt.div = s_r.div - 8'h01;
            end
            spi_pkg::st_keep:
            begin
                if (!master_mode)
                    s_nxt.st = spi_pkg::st_hold;
                else if (head_valid && head.select_number_field == s_r.word.select_number_field)
                begin
                    pop      = 1'b1;
                    s_nxt    = load_word(s_r, head, head_fmt);
                    s_nxt.st = spi_pkg::st_shift;
                end
                else if (head_valid)
                    s_nxt.st = spi_pkg::st_hold;
            end
            spi_pkg::st_hold:
            begin
                if (s_r.dly == 9'h000)
                    s_nxt.st = spi_pkg::st_idle;
                else
                    s_nxt.dly = s_r.dly - 9'h001;
            end
            spi_pkg::st_slv_shift:
            begin
                if (!sel)
                begin
                    s_nxt.somi_oe = 1'b0;
                    s_nxt.st      = spi_pkg::st_slv_early;
                end
                else if (sclk_edge)
                begin
                    if ((sclk_s != cur_fmt.clock_polarity_bit) == cur_fmt.clock_phase_bit)
                    begin
                        s_nxt.sh  = shift_in(s_r.sh, mosi_s, cur_fmt);
                        s_nxt.cnt = s_r.cnt + 6'h01;
                        if (s_nxt.cnt == {1'b0, cur_fmt.char_length_field})
                        begin
                            word_done = 1'b1;
                            s_nxt.st  = spi_pkg::st_idle;
                        end
                    end
                    else
                        s_nxt.somi = out_bit(s_r.sh, cur_fmt);
                end
            end
            spi_pkg::st_slv_early:
            begin
                if (sel)
                begin
                    s_nxt.somi_oe = 1'b1;
                    s_nxt.st      = spi_pkg::st_slv_shift;
                end
                else if (sclk_edge)
                begin
                    len_err  = 1'b1;
                    s_nxt.st = spi_pkg::st_idle;
                end
            end
            default:
                s_nxt.st = spi_pkg::st_idle;
        endcase
        if (!block_enable_bit)
        begin
            s_nxt.st      = spi_pkg::st_idle;
            s_nxt.somi_oe = 1'b0;
        end
        if (word_done)
        begin
            s_nxt.rx_buf = s_nxt.sh;
            s_nxt.dma_rx = dma_request_enable;
        end
        s_nxt.rx_flag  = word_done | (s_r.rx_flag & ~(rx_read | rx_flag_clear));
        s_nxt.len_flag = len_err | (s_r.len_flag & ~len_flag_clear);
    end

    always_ff @(posedge clk)
    begin
        if (!srst_n)
            s_r <= spi_pkg::CORE_RESET;
        else
            s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rx_irq                     = s_r.rx_flag & rx_irq_enable;
    assign len_irq                    = s_r.len_flag & len_irq_enable;
    assign irq_line_zero              = (rx_irq & ~rx_irq_line_select) | (len_irq & ~len_irq_line_select);
    assign irq_line_one               = (rx_irq & rx_irq_line_select) | (len_irq & len_irq_line_select);
    assign rx_buffer_register         = s_r.rx_buf;
    assign rx_complete_flag           = s_r.rx_flag;
    assign length_error_flag          = s_r.len_flag;
    assign dma_tx_request             = dma_request_enable & block_enable_bit & tx_ready;
    assign dma_rx_request             = s_r.dma_rx;
    assign serial_clock_pin_o         = s_r.sclk;
    assign serial_clock_pin_oe        = master_mode & block_enable_bit;
    assign slave_in_master_out_pin_o  = s_r.mosi;
    assign slave_in_master_out_pin_oe = master_mode & block_enable_bit;
    assign slave_out_master_in_pin_o  = s_r.somi;
    assign slave_out_master_in_pin_oe = s_r.somi_oe;
    assign chip_select_pins_o         = (in_setup | in_shift | in_hold | in_keep) ?
                                        s_r.word.select_number_field : select_idle_level_bits;
    assign chip_select_pins_oe        = pin_function & {2{master_mode}};

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!srst_n);

    sequence setup_two_then_shift;
        in_setup [*2] ##1 in_shift;
    endsequence

    sequence hold_one_then_idle;
        in_hold ##1 in_idle;
    endsequence

    AST_RX_FLAG: assert property (word_done |=> rx_complete_flag)
        else $error("receive flag not set after word");
    AST_RX_COPY: assert property (word_done |=> rx_buffer_register == $past(s_nxt.sh))
        else $error("receive buffer not loaded");
    AST_IRQ_ROUTE: assert property ((rx_complete_flag && rx_irq_enable && !len_irq_enable) |->
        (irq_line_one == rx_irq_line_select) && (irq_line_zero != rx_irq_line_select))
        else $error("receive interrupt on wrong line");
    AST_IRQ_OFF: assert property ((!rx_irq_enable && !len_irq_enable) |-> !irq_line_zero && !irq_line_one)
        else $error("interrupt without enable");
    AST_SCLK_IDLE: assert property ((in_setup || in_hold || in_keep) && master_mode |->
        serial_clock_pin_o == cur_fmt.clock_polarity_bit)
        else $error("serial clock active outside shifting");
    AST_CS_SHIFT: assert property (in_shift |-> chip_select_pins_o == s_r.word.select_number_field)
        else $error("select number not driven");
    AST_CS_IDLE: assert property (in_idle |-> chip_select_pins_o == select_idle_level_bits)
        else $error("idle select pattern wrong");
    AST_SETUP: assert property (($rose(in_setup) && s_r.dly == 9'h001 && block_enable_bit) |->
        setup_two_then_shift)
        else $error("setup interval length wrong");
    AST_HOLD: assert property (($rose(in_hold) && s_r.dly == 9'h000) |-> hold_one_then_idle)
        else $error("hold interval length wrong");
    AST_KEEP: assert property ((in_keep && master_mode && block_enable_bit && head_valid &&
        head.select_number_field == s_r.word.select_number_field) |=> in_shift)
        else $error("kept select did not skip setup");
    AST_SOMI_TRI: assert property ((s_r.st == spi_pkg::st_slv_shift && !sel) |=> !slave_out_master_in_pin_oe)
        else $error("slave output not released");
    AST_LEN_ERR: assert property ((s_r.st == spi_pkg::st_slv_early && !sel && sclk_edge && block_enable_bit)
        |=> length_error_flag && in_idle)
        else $error("length error not flagged");
    AST_SOFT_RST: assert property (disable iff (!reset_n) !reset_release |=>
        in_idle && !rx_complete_flag && !length_error_flag)
        else $error("block active while held in reset");

endmodule : spi_core

`default_nettype wire

//--- design/spi_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module spi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   count;
    } fifo_state_s;

    fifo_state_s      s_r;
    fifo_state_s      s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pull;

    assign in_ready  = s_r.count != (AW+1)'(DEPTH);
    assign out_valid = s_r.count != '0;
    assign out_data  = mem[s_r.rd];
    assign push      = in_valid & in_ready;
    assign pull      = out_valid & out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
            s_nxt.wr = (s_r.wr == AW'(DEPTH - 1)) ? '0 : s_r.wr + AW'(1);
        if (pull)
            s_nxt.rd = (s_r.rd == AW'(DEPTH - 1)) ? '0 : s_r.rd + AW'(1);
        s_nxt.count = s_r.count + (AW+1)'(push) - (AW+1)'(pull);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
        if (push)
            mem[s_r.wr] <= in_data;
    end

endmodule : spi_fifo

`default_nettype wire

//--- include/spi_pkg.sv
package spi_pkg;

    localparam int DATA_W      = 16;
    localparam int FIFO_DEPTH  = 32;
    localparam int SYNC_W      = 5;
    // chip-select setup lasts field + 2 clocks, hold lasts field + 1 clock
    localparam int SETUP_EXTRA = 2;
    localparam int HOLD_EXTRA  = 1;

    typedef struct packed {
        logic [7:0] clock_divider_field;
        logic [4:0] char_length_field;
        logic       clock_phase_bit;
        logic       clock_polarity_bit;
        logic       shift_order_bit;
    } word_format_s;

    typedef struct packed {
        logic [7:0] select_setup_field;
        logic [7:0] select_hold_field;
    } select_delay_s;

    typedef struct packed {
        logic [1:0]        format_select_field;
        logic [1:0]        select_number_field;
        logic              select_keep_bit;
        logic [DATA_W-1:0] data;
    } tx_word_s;

    typedef enum logic [2:0] {
        st_idle,
        st_setup,
        st_shift,
        st_hold,
        st_keep,
        st_slv_shift,
        st_slv_early
    } core_state_e;

    typedef struct packed {
        core_state_e       st;
        tx_word_s          word;
        logic [DATA_W-1:0] sh;
        logic [5:0]        cnt;
        logic [7:0]        div;
        logic [8:0]        dly;
        logic              sclk;
        logic              mosi;
        logic              somi;
        logic              somi_oe;
        logic              prev_sclk;
        logic [DATA_W-1:0] rx_buf;
        logic              rx_flag;
        logic              len_flag;
        logic              dma_rx;
    } core_state_s;

    localparam core_state_s CORE_RESET = '0;

endpackage : spi_pkg

//--- testbench/spi_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_core_tb;
    typedef struct packed {spi_pkg::tx_word_s w; logic [15:0] reply; logic line; logic en;} row_s;
    localparam row_s ROWS [3] = '{'{'{2'h0, 2'h2, 1'b0, 16'h00A5}, 16'h003C, 1'b0, 1'b1},
                                 '{'{2'h1, 2'h0, 1'b0, 16'h8001}, 16'hF00F, 1'b1, 1'b1},
                                 '{'{2'h0, 2'h2, 1'b0, 16'h007E}, 16'h0081, 1'b0, 1'b0}};
    logic clk = 0, reset_n = 0, psc = 1, rel = 0, ena = 0, mst = 1, tx_valid = 0, rx_read = 0, line = 0, en = 0;
    spi_pkg::tx_word_s tx_word = '0;
    spi_pkg::word_format_s [3:0] fmt = 64'h0000_0000_0380_0340;
    logic [15:0] rxb;
    logic        rxf, irq0, irq1, sck, mosi, somi, dmar, lenf;
    logic        dma_seen = 0;
    logic [1:0]  cs, cs_seen;
    int          error_cnt = 0, compares = 0;
    always #12.5 clk = ~clk;
    spi_peer u_peer (.sclk(sck), .mosi(mosi), .sel_n(cs[0]), .somi(somi));
    spi_core u_dut (.clk(clk), .reset_n(reset_n), .psc_reset_n(psc), .reset_release(rel),
        .clock_source_bit(mst), .master_bit(mst), .block_enable_bit(ena), .pin_function(2'h3),
        .word_format_register(fmt), .select_delay_register(16'h0000), .select_idle_level_bits(2'h3),
        .rx_irq_enable(en), .len_irq_enable(en), .rx_irq_line_select(line), .len_irq_line_select(line),
        .dma_request_enable(en), .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(), .rx_read(rx_read),
        .rx_flag_clear(1'b0), .len_flag_clear(1'b0), .rx_buffer_register(rxb), .rx_complete_flag(rxf),
        .length_error_flag(lenf), .irq_line_zero(irq0), .irq_line_one(irq1), .dma_tx_request(),
        .dma_rx_request(dmar), .serial_clock_pin_i(sck), .serial_clock_pin_o(sck), .serial_clock_pin_oe(),
        .slave_in_master_out_pin_i(mosi), .slave_in_master_out_pin_o(mosi), .slave_in_master_out_pin_oe(),
        .slave_out_master_in_pin_i(somi), .slave_out_master_in_pin_o(), .slave_out_master_in_pin_oe(),
        .chip_select_pins_i(cs), .chip_select_pins_o(cs), .chip_select_pins_oe());
    ////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic run(input row_s r);
        int          n;
        logic [15:0] m;
        m = r.w.format_select_field[0] ? 16'hFFFF : 16'h00FF;
        u_peer.tx_sh = r.w.format_select_field[0] ? r.reply : r.reply << 8;
        line = r.line;
        en = r.en;
        tx_word = r.w;
        tx_valid = 1;
        dma_seen = 0;
        @(negedge clk);
        tx_valid = 0;
        for (n = 0; n < 3000 && rxf !== 1'b1; n++)
        begin
            @(negedge clk);
            if (dmar === 1'b1)
                dma_seen = 1;
            if (sck === 1'b1)
                cs_seen = cs;
        end
        if (n == 3000)
        begin
            error_cnt++;
            end_sim();
        end
        check("rx flag", rxf, 1);
        check("rx buffer", rxb & m, r.reply);
        check("peer data", u_peer.rx_sh & m, r.w.data & m);
        check("select", cs_seen, r.w.select_number_field);
        check("irq", {irq1, irq0}, r.en ? (r.line ? 2 : 1) : 0);
        check("dma rx", dma_seen, r.en);
        check("len flag", lenf, 0);
        repeat (6) @(negedge clk);
        check("idle select", cs, 2'h3);
        check("idle sclk", sck, 0);
        rx_read = 1;
        @(negedge clk);
        rx_read = 0;
        @(negedge clk);
        check("flag cleared", rxf, 0);
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(negedge clk);
        reset_n = 1;
        rel = 1;
        @(negedge clk);
        ena = 1;
        foreach (ROWS[i])
            run(ROWS[i]);
        // reset bit cleared in mid-word
        tx_word = ROWS[1].w;
        tx_valid = 1;
        @(negedge clk);
        tx_valid = 0;
        repeat (40) @(negedge clk);
        rel = 0;
        repeat (3) @(negedge clk);
        check("held flag", rxf, 0);
        check("held buffer", rxb, 0);
        check("held sclk", sck, 0);
        rel = 1;
        run(ROWS[1]);
        psc = 0;
        repeat (3) @(negedge clk);
        check("psc buffer", rxb, 0);
        end_sim();
    end
endmodule : spi_core_tb
`default_nettype wire

//--- testbench/spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic sel_n,
    output logic      somi
);
    logic [15:0] tx_sh = '0;
    logic [15:0] rx_sh = '0;
    logic        bit_r = 1'b0;
    always @(posedge sclk)
    begin
        bit_r <= tx_sh[15];
        tx_sh <= {tx_sh[14:0], 1'b0};
    end
    always @(negedge sclk)
        rx_sh <= {rx_sh[14:0], mosi};
    // not selected: the line drives the inverted bit_r level
    assign somi = sel_n ? ~bit_r : bit_r;
endmodule : spi_peer
`default_nettype wire
